/* File: hw/gps_pkg.sv */
package gps_pkg;

  // ************************************************************
  // register numbers and PHY address (5-bit management addresses)
  // ************************************************************
  localparam logic [4:0] GPS_REG_CTRL0 = 5'h00;
  localparam logic [4:0] GPS_REG_GIG_STATUS = 5'h0a;
  localparam logic [4:0] GPS_REG_EXT_STATUS = 5'h0f;
  localparam logic [4:0] GPS_REG_COPPER_CTRL = 5'h10;
  localparam logic [4:0] GPS_PHY_ADDR = 5'h01;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int GPS_SW_RESET_BIT = 15;
  localparam int GPS_MS_FAULT_BIT = 15;
  localparam int GPS_MS_MASTER_BIT = 14;
  localparam int GPS_LOCAL_RX_BIT = 13;
  localparam int GPS_REMOTE_RX_BIT = 12;
  localparam int GPS_LP_FD_BIT = 11;
  localparam int GPS_LP_HD_BIT = 10;
  localparam int GPS_CC_LP_DIS_BIT = 15;
  localparam int GPS_CC_DS_CNT_LSB = 12;
  localparam int GPS_CC_DS_EN_BIT = 11;
  localparam int GPS_CC_FORCE_BIT = 10;
  localparam int GPS_CC_ED_LSB = 8;
  localparam int GPS_CC_EXT_DIST_BIT = 7;

  // ************************************************************
  // reset and fixed values
  // ************************************************************
  localparam logic [15:0] GPS_EXT_STATUS_VAL = 16'h3000;
  localparam logic [2:0] GPS_DS_CNT_RST = 3'h3;
  localparam logic [7:0] GPS_IDLE_MAX = 8'hff;

  // energy detect field encodings
  typedef enum logic [1:0] {
    GPS_ED_OFF0 = 2'b00,
    GPS_ED_OFF1 = 2'b01,
    GPS_ED_SENSE = 2'b10,
    GPS_ED_SENSE_TX = 2'b11
  } gps_ed_mode_t;

  // copper control fields (stored bits only)
  typedef struct packed {
    logic lp_dis;
    logic [2:0] ds_cnt;
    logic ds_en;
    logic force_good;
    logic [1:0] ed;
    logic ext_dist;
  } gps_cc_t;

  // management register access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] phy;
    logic [4:0] reg_num;
    logic [15:0] wdata;
  } gps_mgmt_req_t;

  // link-side status inputs
  typedef struct packed {
    logic ms_fault;
    logic ms_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic lp_fd;
    logic lp_hd;
    logic idle_err;
  } gps_link_stat_t;

endpackage : gps_pkg

/* File: hw/gps_idle_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_idle_counter
  import gps_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // events
  input wire logic inc,
  input wire logic clr,
  output logic [W-1:0] count
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      // an error seen during the clearing read starts the new count
      cnt_d = inc ? W'(1) : '0;
    end else if (inc && cnt_q != '1) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;

endmodule // gps_idle_counter
`default_nettype wire

/* File: hw/gps_fault_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_fault_latch
  import gps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // event and clear
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  logic flag_q;
  logic flag_d;

  // set beats clear so a fault during the read is kept
  always_comb begin
    flag_d = set | (flag_q & ~clr);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

endmodule // gps_fault_latch
`default_nettype wire

/* File: hw/gps_regs.sv */
// Summary of operation
// - master/slave fault latched in status bit 15, cleared on read.
// - status bit 14 shows resolved master (1) or slave (0).
// - status bit 13 shows local receiver operational.
// - status bit 12 shows remote receiver operational.
// - status bit 11 shows partner gigabit full-duplex ability.
// - status bit 10 shows partner gigabit half-duplex ability.
// - idle errors counted in bits 7:0 since last read, cleared by read.
// - idle error count saturates at all ones, never wraps.
// - extended status bits 15 and 14 always read zero.
// - extended status bits 13,12 read one; bits 11:0 read zero.
// - copper control bit 15 stops link pulses; both resets clear it.
// - downshift count bits 14:12 give attempts minus one; resets to 3.
// - downshift only when copper control bit 11 is set; resets off.
// - downshift count and enable take effect at next software reset.
// - bit 10 forces link up except in gigabit mode.
// - energy detect 0x off, 10 sense only, 11 sense and send pulses.
// - hardware reset loads energy detect bits from the strap.
// - bit 7 selects lowered 10 Mb/s receive threshold.
// - software reset is writing 1 to control register 0 bit 15.
`timescale 1ns/1ps
`default_nettype none
module gps_regs
  import gps_pkg::*;
#(
  parameter int IDLE_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // strap sampled after hardware reset
  input wire logic [1:0] energy_detect_strap,
  // management access
  input wire gps_mgmt_req_t mgmt,
  output logic [15:0] rdata,
  output logic rvalid,
  // link status from the copper engine
  input wire gps_link_stat_t link,
  input wire logic gig_mode,
  input wire logic link_sm_up,
  // applied controls
  output logic link_pulse_off,
  output logic [2:0] ds_attempts_m1,
  output logic ds_enable,
  output logic link_up,
  output logic ed_sense,
  output logic ed_tx_nlp,
  output logic low_threshold,
  output logic sw_reset_pulse
);

  // ************************************************************
  // access decode
  // ************************************************************
  logic sel;
  logic rd_gig;
  logic wr_cc;
  logic sw_rst;
  assign sel = (mgmt.phy == GPS_PHY_ADDR);
  assign rd_gig = sel & mgmt.rd & (mgmt.reg_num == GPS_REG_GIG_STATUS);
  assign wr_cc = sel & mgmt.wr & (mgmt.reg_num == GPS_REG_COPPER_CTRL);
  assign sw_rst = sel & mgmt.wr & (mgmt.reg_num == GPS_REG_CTRL0)
    & mgmt.wdata[GPS_SW_RESET_BIT];

  // ************************************************************
  // sticky fault and idle counter
  // ************************************************************
  logic ms_fault;
  logic [IDLE_W-1:0] idle_cnt;

  gps_fault_latch u_fault (
    .clk(clk),
    .nrst(nrst),
    .set(link.ms_fault),
    .clr(rd_gig),
    .flag(ms_fault)
  );

  gps_idle_counter #(.W(IDLE_W)) u_idle (
    .clk(clk),
    .nrst(nrst),
    .inc(link.idle_err),
    .clr(rd_gig),
    .count(idle_cnt)
  );

  // ************************************************************
  // copper control register
  // ************************************************************
  gps_cc_t cc_q;
  gps_cc_t cc_d;
  gps_cc_t act_q;
  gps_cc_t act_d;
  logic strap_pend_q;
  logic strap_pend_d;

  always_comb begin
    cc_d = cc_q;
    act_d = act_q;
    strap_pend_d = 1'b0;
    if (strap_pend_q) begin
      cc_d.ed = energy_detect_strap;
      act_d.ed = energy_detect_strap;
    end
    if (wr_cc) begin
      cc_d.lp_dis = mgmt.wdata[GPS_CC_LP_DIS_BIT];
      cc_d.ds_cnt = mgmt.wdata[GPS_CC_DS_CNT_LSB +: 3];
      cc_d.ds_en = mgmt.wdata[GPS_CC_DS_EN_BIT];
      cc_d.force_good = mgmt.wdata[GPS_CC_FORCE_BIT];
      cc_d.ed = mgmt.wdata[GPS_CC_ED_LSB +: 2];
      cc_d.ext_dist = mgmt.wdata[GPS_CC_EXT_DIST_BIT];
    end
    // immediate fields follow the stored copy
    act_d.lp_dis = cc_d.lp_dis;
    act_d.force_good = cc_d.force_good;
    act_d.ext_dist = cc_d.ext_dist;
    if (sw_rst) begin
      // software reset clears link pulse disable
      cc_d.lp_dis = 1'b0;
      act_d.lp_dis = 1'b0;
      // pending values applied at software reset
      act_d.ds_cnt = cc_q.ds_cnt;
      act_d.ds_en = cc_q.ds_en;
      act_d.ed = cc_q.ed;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cc_q <= '{lp_dis: 1'b0, ds_cnt: GPS_DS_CNT_RST, ds_en: 1'b0,
                force_good: 1'b0, ed: 2'h0, ext_dist: 1'b0};
      act_q <= '{lp_dis: 1'b0, ds_cnt: GPS_DS_CNT_RST, ds_en: 1'b0,
                 force_good: 1'b0, ed: 2'h0, ext_dist: 1'b0};
      strap_pend_q <= 1'b1;
    end else begin
      cc_q <= cc_d;
      act_q <= act_d;
      strap_pend_q <= strap_pend_d;
    end
  end

  // ************************************************************
  // applied outputs (all registered)
  // ************************************************************
  logic lp_off_q;
  logic [2:0] ds_q;
  logic ds_en_q;
  logic up_q;
  logic ed_s_q;
  logic ed_t_q;
  logic thr_q;
  logic swr_q;
  logic lp_off_d;
  logic [2:0] ds_d;
  logic ds_en_d;
  logic up_d;
  logic ed_s_d;
  logic ed_t_d;
  logic thr_d;

  always_comb begin
    lp_off_d = act_q.lp_dis;
    ds_d = act_q.ds_cnt;
    ds_en_d = act_q.ds_en;
    up_d = link_sm_up | (act_q.force_good & ~gig_mode);
    unique case (gps_ed_mode_t'(act_q.ed))
      GPS_ED_OFF0, GPS_ED_OFF1: begin
        ed_s_d = 1'b0;
        ed_t_d = 1'b0;
      end
      GPS_ED_SENSE: begin
        ed_s_d = 1'b1;
        ed_t_d = 1'b0;
      end
      GPS_ED_SENSE_TX: begin
        ed_s_d = 1'b1;
        ed_t_d = 1'b1;
      end
    endcase
    thr_d = act_q.ext_dist;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lp_off_q <= 1'b0;
      ds_q <= GPS_DS_CNT_RST;
      ds_en_q <= 1'b0;
      up_q <= 1'b0;
      ed_s_q <= 1'b0;
      ed_t_q <= 1'b0;
      thr_q <= 1'b0;
      swr_q <= 1'b0;
    end else begin
      lp_off_q <= lp_off_d;
      ds_q <= ds_d;
      ds_en_q <= ds_en_d;
      up_q <= up_d;
      ed_s_q <= ed_s_d;
      ed_t_q <= ed_t_d;
      thr_q <= thr_d;
      swr_q <= sw_rst;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  logic [15:0] rd_d;
  logic [15:0] rd_q;
  logic rv_q;

  always_comb begin
    rd_d = 16'h0000;
    unique case (mgmt.reg_num)
      GPS_REG_GIG_STATUS: begin
        rd_d[GPS_MS_FAULT_BIT] = ms_fault;
        rd_d[GPS_MS_MASTER_BIT] = link.ms_master;
        rd_d[GPS_LOCAL_RX_BIT] = link.local_rx_ok;
        rd_d[GPS_REMOTE_RX_BIT] = link.remote_rx_ok;
        rd_d[GPS_LP_FD_BIT] = link.lp_fd;
        rd_d[GPS_LP_HD_BIT] = link.lp_hd;
        rd_d[7:0] = idle_cnt[7:0];
      end
      GPS_REG_EXT_STATUS: rd_d = GPS_EXT_STATUS_VAL;
      GPS_REG_COPPER_CTRL: begin
        rd_d[GPS_CC_LP_DIS_BIT] = cc_q.lp_dis;
        rd_d[GPS_CC_DS_CNT_LSB +: 3] = cc_q.ds_cnt;
        rd_d[GPS_CC_DS_EN_BIT] = cc_q.ds_en;
        rd_d[GPS_CC_FORCE_BIT] = cc_q.force_good;
        rd_d[GPS_CC_ED_LSB +: 2] = cc_q.ed;
        rd_d[GPS_CC_EXT_DIST_BIT] = cc_q.ext_dist;
      end
      default: rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= 16'h0000;
      rv_q <= 1'b0;
    end else begin
      // read by register number at PHY address 1
      rd_q <= (sel & mgmt.rd) ? rd_d : 16'h0000;
      rv_q <= sel & mgmt.rd;
    end
  end

  assign rdata = rd_q;
  assign rvalid = rv_q;
  assign link_pulse_off = lp_off_q;
  assign ds_attempts_m1 = ds_q;
  assign ds_enable = ds_en_q;
  assign link_up = up_q;
  assign ed_sense = ed_s_q;
  assign ed_tx_nlp = ed_t_q;
  assign low_threshold = thr_q;
  assign sw_reset_pulse = swr_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence fault_then_read_s;
    link.ms_fault ##1 !link.ms_fault ##1 (!link.ms_fault && rd_gig);
  endsequence

  fault_read_a: assert property (
    fault_then_read_s |=> rv_q && rd_q[GPS_MS_FAULT_BIT]
  ) else $error("fault bit not reported on read");

  fault_clear_a: assert property (
    (rd_gig && !link.ms_fault) ##1 !link.ms_fault
      ##1 (!link.ms_fault && rd_gig) |=> !rd_q[GPS_MS_FAULT_BIT]
  ) else $error("fault bit not cleared by read");

  role_read_a: assert property (
    rd_gig |=> rd_q[GPS_MS_MASTER_BIT] == $past(link.ms_master)
  ) else $error("role bit wrong");

  idle_sat_a: assert property (
    (idle_cnt == GPS_IDLE_MAX[IDLE_W-1:0] && !rd_gig)
      |=> idle_cnt == GPS_IDLE_MAX[IDLE_W-1:0]
  ) else $error("idle counter wrapped");

  idle_clr_a: assert property (
    (rd_gig && !link.idle_err) |=> idle_cnt == '0
  ) else $error("idle counter not cleared");

  ext_fixed_a: assert property (
    (sel && mgmt.rd && mgmt.reg_num == GPS_REG_EXT_STATUS)
      |=> rd_q == 16'h3000
  ) else $error("extended status wrong");

  ds_hold_a: assert property (
    (!sw_rst && act_q.ds_cnt != cc_q.ds_cnt) |=> ##1 ds_q == $past(ds_q)
  ) else $error("downshift applied without reset");

  force_a: assert property (
    (act_q.force_good && !gig_mode) |=> link_up
  ) else $error("forced link not up");

  lp_swr_a: assert property (
    sw_rst |=> ##1 !link_pulse_off
  ) else $error("link pulse disable survived reset");

endmodule // gps_regs
`default_nettype wire

/* File: tb/gps_lp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_lp_model
  import gps_pkg::*;
(
  // clock
  input wire logic clk,
  // status toward the device
  output var gps_link_stat_t link
);
  initial link = '0;

  // levels change off the sampling edge and settle two cycles
  task automatic set_lv(input logic [5:0] v);
    @(negedge clk);
    link[6:1] = v;
    repeat (2) @(negedge clk);
  endtask

  // one-cycle configuration fault, then quiet
  task automatic fault_pulse();
    @(negedge clk);
    link.ms_fault = 1'b1;
    @(negedge clk);
    link.ms_fault = 1'b0;
  endtask

  // back-to-back idle error pulses, one per cycle
  task automatic errs(input int n);
    repeat (n) begin
      @(negedge clk);
      link.idle_err = 1'b1;
    end
    @(negedge clk);
    link.idle_err = 1'b0;
  endtask
endmodule // gps_lp_model
`default_nettype wire

/* File: tb/gps_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_regs_tb
  import gps_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] strap = 2'b10;
  gps_mgmt_req_t mgmt = '0;
  logic gig_mode = 1'b0;
  logic link_sm_up = 1'b0;
  gps_link_stat_t link;
  logic [15:0] rdata;
  logic rvalid;
  logic link_pulse_off;
  logic [2:0] ds_attempts_m1;
  logic ds_enable;
  logic link_up;
  logic ed_sense;
  logic ed_tx_nlp;
  logic low_threshold;
  logic sw_reset_pulse;
  logic [15:0] rd_q;
  logic rv_q;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int sw_cnt = 0;

  always #2 clk = ~clk;

  gps_regs gps_regs_inst (.clk(clk), .nrst(nrst),
    .energy_detect_strap(strap), .mgmt(mgmt), .rdata(rdata),
    .rvalid(rvalid), .link(link), .gig_mode(gig_mode),
    .link_sm_up(link_sm_up), .link_pulse_off(link_pulse_off),
    .ds_attempts_m1(ds_attempts_m1), .ds_enable(ds_enable),
    .link_up(link_up), .ed_sense(ed_sense), .ed_tx_nlp(ed_tx_nlp),
    .low_threshold(low_threshold), .sw_reset_pulse(sw_reset_pulse));
  gps_lp_model gps_lp_model_inst (.clk(clk), .link(link));

  // ************************************************************
  // helpers
  // ************************************************************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (sw_reset_pulse === 1'b1) begin
      sw_cnt <= sw_cnt + 1;
    end
    // longest run is well under this
    if (cycles == 6000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one access; answer sampled in the cycle after it is taken
  task automatic acc(input logic r, input logic [4:0] phy,
                     input logic [4:0] num, input logic [15:0] wd);
    @(negedge clk);
    mgmt = '{rd: r, wr: ~r, phy: phy, reg_num: num, wdata: wd};
    @(negedge clk);
    mgmt = '0;
    rv_q = rvalid;
    rd_q = rdata;
  endtask

  task automatic rd(input logic [4:0] num);
    acc(1'b1, GPS_PHY_ADDR, num, 16'h0000);
  endtask

  // write, then let the applied outputs settle two cycles
  task automatic wr(input logic [4:0] num, input logic [15:0] wd);
    acc(1'b0, GPS_PHY_ADDR, num, wd);
    repeat (2) @(negedge clk);
  endtask

  task automatic hw_reset();
    @(negedge clk);
    nrst = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rd(GPS_REG_EXT_STATUS);
    chk(rd_q, 16'h3000);
    rd(GPS_REG_COPPER_CTRL);
    chk(rd_q, 16'h3200);
    chk({13'h0, ds_attempts_m1}, 16'h0003);
    chk({14'h0, ed_tx_nlp, ed_sense}, 16'h0001);
    rd(GPS_REG_GIG_STATUS);
    chk(rd_q, 16'h0000);
    rd(5'h05);
    chk({15'h0, rv_q}, 16'h0001);
    chk(rd_q, 16'h0000);
    acc(1'b1, 5'h02, GPS_REG_EXT_STATUS, 16'h0000);
    chk({15'h0, rv_q}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_status();
    logic [4:0] v;
    for (int i = 0; i < 7; i++) begin
      v = (i == 5) ? 5'h1f : (i == 6) ? 5'h00 : 5'h01 << i;
      gps_lp_model_inst.set_lv({1'b0, v});
      rd(GPS_REG_GIG_STATUS);
      chk(rd_q, {1'b0, v, 10'h000});
    end
    $display("test status done");
  endtask

  task automatic t_fault();
    gps_lp_model_inst.set_lv(6'h20);
    gps_lp_model_inst.set_lv(6'h00);
    rd(GPS_REG_GIG_STATUS);
    chk(rd_q, 16'h8000);
    rd(GPS_REG_GIG_STATUS);
    chk(rd_q, 16'h0000);
    gps_lp_model_inst.fault_pulse();
    rd(GPS_REG_GIG_STATUS);
    chk(rd_q, 16'h8000);
    $display("test fault done");
  endtask

  task automatic t_idle();
    gps_lp_model_inst.errs(5);
    rd(GPS_REG_GIG_STATUS);
    chk(rd_q, 16'h0005);
    gps_lp_model_inst.errs(300);
    rd(GPS_REG_GIG_STATUS);
    chk(rd_q, 16'h00ff);
    rd(GPS_REG_GIG_STATUS);
    chk(rd_q, 16'h0000);
    $display("test idle done");
  endtask

  task automatic t_copper();
    logic [1:0] m;
    wr(GPS_REG_COPPER_CTRL, 16'h8480);
    rd(GPS_REG_COPPER_CTRL);
    chk(rd_q, 16'h8480);
    chk({14'h0, link_pulse_off, low_threshold}, 16'h0003);
    chk({15'h0, link_up}, 16'h0001);
    chk({14'h0, ed_tx_nlp, ed_sense}, 16'h0001);
    @(negedge clk);
    gig_mode = 1'b1;
    repeat (3) @(negedge clk);
    chk({15'h0, link_up}, 16'h0000);
    link_sm_up = 1'b1;
    repeat (3) @(negedge clk);
    chk({15'h0, link_up}, 16'h0001);
    gig_mode = 1'b0;
    link_sm_up = 1'b0;
    wr(GPS_REG_COPPER_CTRL, 16'hfb00);
    chk({12'h0, ds_enable, ds_attempts_m1}, 16'h0003);
    chk({14'h0, link_pulse_off, low_threshold}, 16'h0002);
    wr(GPS_REG_CTRL0, 16'h8000);
    chk({12'h0, ds_enable, ds_attempts_m1}, 16'h000f);
    chk({14'h0, ed_tx_nlp, ed_sense}, 16'h0003);
    chk({15'h0, link_pulse_off}, 16'h0000);
    chk(sw_cnt[15:0], 16'h0001);
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(GPS_REG_COPPER_CTRL, {6'h00, m, 8'h00});
      wr(GPS_REG_CTRL0, 16'h8000);
      chk({14'h0, ed_tx_nlp, ed_sense}, {14'h0, m[1] & m[0], m[1]});
    end
    chk({12'h0, ds_enable, ds_attempts_m1}, 16'h0000);
    $display("test copper done");
  endtask

  task automatic t_hwreset();
    wr(GPS_REG_COPPER_CTRL, 16'h8480);
    strap = 2'b11;
    hw_reset();
    rd(GPS_REG_COPPER_CTRL);
    chk(rd_q, 16'h3300);
    chk({14'h0, ed_tx_nlp, ed_sense}, 16'h0003);
    $display("test hwreset done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_status();
    t_fault();
    t_idle();
    t_copper();
    t_hwreset();
    final_report();
  end
endmodule // gps_regs_tb
`default_nettype wire
